// ===== core/tmr2_consts.svh
// Purpose: Constants for the timer 2 reload/capture register block
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes: Index registers are scaled by four for the byte address
`ifndef TMR2_CONSTS_SVH
`define TMR2_CONSTS_SVH
// ==========================================
// Register indices and byte address width
`define TMR2_IDX_CTRL 8'hC8
`define TMR2_IDX_RLL 8'hCA
`define TMR2_IDX_RLH 8'hCB
`define TMR2_IDX_CNTL 8'hCC
`define TMR2_IDX_CNTH 8'hCD
`define TMR2_IDX_CKSEL 8'h8E
`define TMR2_IDX_IRQ_ST 8'hD0
`define TMR2_IDX_IRQ_EN 8'hD1
`define TMR2_IDX_IRQ_CLR 8'hD2
`define TMR2_ADDR_W 12
// ==========================================
// Control field positions
`define TMR2_B_OVH 7
`define TMR2_B_OVL 6
`define TMR2_B_OVLEN 5
`define TMR2_B_CE 4
`define TMR2_B_SPLIT 3
`define TMR2_B_RUN 2
`define TMR2_B_CSS 1
`define TMR2_B_XCLK 0
// Clock select register fields
`define TMR2_B_CKH 1
`define TMR2_B_CKL 0
// Interrupt status fields
`define TMR2_I_OVH 0
`define TMR2_I_OVL 1
`define TMR2_I_CAP 2
`define TMR2_IRQ_W 3
// ==========================================
// Reset values and timing
`define TMR2_RST_BYTE 8'h00
`define TMR2_DIV12 12
`define TMR2_DIV8 8
`define TMR2_CLK_NS 4
`endif

// ===== core/tmr2_pkg.sv
// Purpose: Types for the timer 2 block
// Assumes: Nothing beyond the constants header
// Notes: Only types live here
package tmr2_pkg;
	typedef enum logic [1:0] {TMR2_SRC_CORE, TMR2_SRC_DIV12, TMR2_SRC_EXT8} tmr2_src_e;
	typedef logic [7:0] tmr2_byte_t;
endpackage

// ===== core/tmr2_tick.sv
// Purpose: Per-byte tick enable generator
// Assumes: ext_clk is synchronous to aclk
// Notes: Prescalers are shared by both byte timers
`include "tmr2_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tmr2_tick import tmr2_pkg::*; #(
	parameter int DIV_CORE = `TMR2_DIV12,
	parameter int DIV_EXT = `TMR2_DIV8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ext_clk,
	input wire logic sel_h,
	input wire logic sel_l,
	input wire logic xclk,
	output logic tick_h,
	output logic tick_l
);
	// Counters are eight bits wide, so a divider beyond 255 cannot be served
	if (DIV_CORE < 2 || DIV_CORE > 255 || DIV_EXT < 2 || DIV_EXT > 255) begin : g_bad_div
		$error("tmr2_tick: divider out of range");
	end
	logic [7:0] div12_r;
	logic [7:0] div8_r;
	logic ext_d_r;
	logic t12;
	logic t8;
	// ==========================================
	// Prescalers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div12_r <= 8'h00;
		end else if (div12_r == 8'(DIV_CORE - 1)) begin
			div12_r <= 8'h00;
		end else begin
			div12_r <= div12_r + 8'h01;
		end
	end
	// External clock counted on its rising edges, inputs treated as synchronous
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_d_r <= 1'b0;
			div8_r <= 8'h00;
		end else begin
			ext_d_r <= ext_clk;
			if (ext_clk && !ext_d_r) begin
				div8_r <= (div8_r == 8'(DIV_EXT - 1)) ? 8'h00 : div8_r + 8'h01;
			end
		end
	end
	assign t12 = (div12_r == 8'(DIV_CORE - 1));
	assign t8 = ext_clk && !ext_d_r && (div8_r == 8'(DIV_EXT - 1));
	// ==========================================
	// Source select per byte
	assign tick_h = sel_h ? 1'b1 : (xclk ? t8 : t12);
	assign tick_l = sel_l ? 1'b1 : (xclk ? t8 : t12);
endmodule
`default_nettype wire

// ===== core/tmr2_top.sv
// Purpose: Timer 2 with reload and capture, AXI4-Lite register access
// Assumes: Capture inputs and ext_clk synchronous to aclk
// Notes: Registers at byte address four times their index
// Behaviour
// - Auto-reload takes low byte from reload-low
// - Capture writes count-low into reload-low
// - 16-bit mode: count-high is upper count byte
// - Split mode: count-high is own 8-bit timer
// - Split: run gates high byte only
// - Capture source: SOF or slow-oscillator falling edge
// - Capture latches both bytes, raises interrupt
// - Per-byte clock: core or prescaled; div12 or ext div8 shared
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "tmr2_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tmr2_top import tmr2_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_clk,
	input wire logic usb_sof,
	input wire logic slow_osc,
	output logic irq
);
	tmr2_byte_t ctrl_r, rll_r, rlh_r, cntl_r, cnth_r;
	logic [1:0] cksel_r;
	logic [`TMR2_IRQ_W-1:0] ist_r, ien_r, ev;
	logic aw_hold_r, w_hold_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wr_go;
	logic [9:0] widx, ridx;
	logic rmapped;
	logic [31:0] rd_val;
	logic osc_d_r;
	logic cap_ev, tick_h, tick_l;
	logic ovl, ovh;
	logic split, ce, run;
	logic wr_ctrl, wr_rll, wr_rlh, wr_cntl, wr_cnth;
	logic [7:0] wb;
	assign split = ctrl_r[`TMR2_B_SPLIT];
	assign ce = ctrl_r[`TMR2_B_CE];
	assign run = ctrl_r[`TMR2_B_RUN];
	// ==========================================
	// AXI4-Lite write channel
	assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
	assign wr_go = aw_hold_r && w_hold_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// Byte lane 0 only; a write without wstrb[0] is dropped via wr_en below
	logic wstrb0_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstrb0_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wstrb0_r <= s_axi_wstrb[0];
		end
	end
	assign widx = awaddr_r[11:2];
	assign wb = wdata_r[7:0];
	// Unmapped writes are dropped silently, so the response is always OKAY
	assign s_axi_bresp = 2'h0;
	logic wr_en;
	assign wr_en = wr_go && wstrb0_r;
	assign wr_ctrl = wr_en && widx == 10'(`TMR2_IDX_CTRL);
	assign wr_rll = wr_en && widx == 10'(`TMR2_IDX_RLL);
	assign wr_rlh = wr_en && widx == 10'(`TMR2_IDX_RLH);
	assign wr_cntl = wr_en && widx == 10'(`TMR2_IDX_CNTL);
	assign wr_cnth = wr_en && widx == 10'(`TMR2_IDX_CNTH);
	// ==========================================
	// AXI4-Lite read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign ridx = s_axi_araddr[11:2];
	always_comb begin
		rmapped = 1'b1;
		case (ridx)
			10'(`TMR2_IDX_CTRL): rd_val = {24'h000000, ctrl_r};
			10'(`TMR2_IDX_RLL): rd_val = {24'h000000, rll_r};
			10'(`TMR2_IDX_RLH): rd_val = {24'h000000, rlh_r};
			10'(`TMR2_IDX_CNTL): rd_val = {24'h000000, cntl_r};
			10'(`TMR2_IDX_CNTH): rd_val = {24'h000000, cnth_r};
			10'(`TMR2_IDX_CKSEL): rd_val = {30'h00000000, cksel_r};
			10'(`TMR2_IDX_IRQ_ST): rd_val = {29'h00000000, ist_r};
			10'(`TMR2_IDX_IRQ_EN): rd_val = {29'h00000000, ien_r};
			10'(`TMR2_IDX_IRQ_CLR): rd_val = 32'h0000_0000;
			default: begin
				rd_val = 32'h0000_0000;
				rmapped = 1'b0;
			end
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rmapped ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// ==========================================
	// Clock enables and capture event
	tmr2_tick u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.ext_clk(ext_clk),
		.sel_h(cksel_r[`TMR2_B_CKH]),
		.sel_l(cksel_r[`TMR2_B_CKL]),
		.xclk(ctrl_r[`TMR2_B_XCLK]),
		.tick_h(tick_h),
		.tick_l(tick_l)
	);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_d_r <= 1'b0;
		end else begin
			osc_d_r <= slow_osc;
		end
	end
	assign cap_ev = ce && (ctrl_r[`TMR2_B_CSS] ? (osc_d_r && !slow_osc) : usb_sof);
	// ==========================================
	// Counters
	logic inc_l, inc_h;
	// Split: low byte free-running, high byte gated by run; 16-bit: run gates all
	assign inc_l = split ? tick_l : (run && tick_l);
	assign inc_h = split ? (run && tick_h) : (inc_l && cntl_r == 8'hFF);
	assign ovl = inc_l && cntl_r == 8'hFF;
	assign ovh = inc_h && cnth_r == 8'hFF;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cntl_r <= `TMR2_RST_BYTE;
		end else if (wr_cntl) begin
			cntl_r <= wb;
		end else if (inc_l) begin
			if (ovl && !ce && (split || cnth_r == 8'hFF)) begin
				cntl_r <= rll_r;
			end else begin
				cntl_r <= cntl_r + 8'h01;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnth_r <= `TMR2_RST_BYTE;
		end else if (wr_cnth) begin
			cnth_r <= wb;
		end else if (inc_h) begin
			cnth_r <= (ovh && !ce) ? rlh_r : cnth_r + 8'h01;
		end
	end
	// ==========================================
	// Reload registers, capture target in capture mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rll_r <= `TMR2_RST_BYTE;
			rlh_r <= `TMR2_RST_BYTE;
		end else if (cap_ev) begin
			rll_r <= cntl_r;
			rlh_r <= cnth_r;
		end else begin
			if (wr_rll) begin
				rll_r <= wb;
			end
			if (wr_rlh) begin
				rlh_r <= wb;
			end
		end
	end
	// ==========================================
	// Control, clock select; hardware flag set wins over software write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `TMR2_RST_BYTE;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= wb;
			end
			if (ovh || cap_ev) begin
				ctrl_r[`TMR2_B_OVH] <= 1'b1;
			end
			if (ovl) begin
				ctrl_r[`TMR2_B_OVL] <= 1'b1;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cksel_r <= 2'h0;
		end else if (wr_en && widx == 10'(`TMR2_IDX_CKSEL)) begin
			cksel_r <= wb[1:0];
		end
	end
	// ==========================================
	// Interrupt status, enable, clear
	assign ev[`TMR2_I_OVH] = ovh;
	assign ev[`TMR2_I_OVL] = ovl && ctrl_r[`TMR2_B_OVLEN];
	assign ev[`TMR2_I_CAP] = cap_ev;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ist_r <= 3'h0;
			ien_r <= 3'h0;
		end else begin
			if (wr_en && widx == 10'(`TMR2_IDX_IRQ_EN)) begin
				ien_r <= wb[`TMR2_IRQ_W-1:0];
			end
			if (wr_en && widx == 10'(`TMR2_IDX_IRQ_CLR)) begin
				ist_r <= (ist_r & ~wb[`TMR2_IRQ_W-1:0]) | ev;
			end else begin
				ist_r <= ist_r | ev;
			end
		end
	end
	assign irq = |(ist_r & ien_r);
	// ==========================================
	// Checks
	chk_split_low_free: assert property (@(posedge aclk) disable iff (!aresetn)
		split && !run && tick_l && !wr_cntl && !ovl |=> cntl_r == $past(cntl_r) + 8'h01)
		else $error("low byte stalled in split mode");
	chk_split_high_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		split && !run && !wr_cnth |=> cnth_r == $past(cnth_r))
		else $error("high byte ran while stopped");
	chk_cap_low: assert property (@(posedge aclk) disable iff (!aresetn)
		cap_ev |=> rll_r == $past(cntl_r))
		else $error("capture low byte wrong");
	chk_cap_both: assert property (@(posedge aclk) disable iff (!aresetn)
		cap_ev |=> rlh_r == $past(cnth_r) && ist_r[`TMR2_I_CAP])
		else $error("capture high byte or flag wrong");
	chk_reload_16: assert property (@(posedge aclk) disable iff (!aresetn)
		!split && !ce && ovh && !wr_cntl && !wr_cnth && !wr_rll && !wr_rlh
		|=> {cnth_r, cntl_r} == {rlh_r, rll_r} && ctrl_r[`TMR2_B_OVH])
		else $error("16-bit reload wrong");
	chk_carry_16: assert property (@(posedge aclk) disable iff (!aresetn)
		!split && !ce && inc_l && cntl_r != 8'hFF && !wr_cnth |=> cnth_r == $past(cnth_r))
		else $error("high byte moved without carry");
	chk_src_lfo: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && ctrl_r[`TMR2_B_CSS] && $fell(slow_osc) |-> cap_ev)
		else $error("falling edge not captured");
	chk_core_tick: assert property (@(posedge aclk) disable iff (!aresetn)
		cksel_r[`TMR2_B_CKL] |-> tick_l)
		else $error("core clock select lost ticks");
	chk_split_high: assert property (@(posedge aclk) disable iff (!aresetn)
		split && run && tick_h && !ce && cnth_r == 8'hFF && !wr_cnth |=> cnth_r == $past(rlh_r))
		else $error("split high byte reload wrong");
	cov_cap: cover property (@(posedge aclk) cap_ev);
	cov_ovh16: cover property (@(posedge aclk) !split && ovh);
	cov_split_ovl: cover property (@(posedge aclk) split && ovl);
	cov_irq: cover property (@(posedge aclk) $rose(irq));
endmodule
`default_nettype wire

// ===== bench/timer2_reload_capture_regs_tb.sv
// Purpose: Self-checking bench for the timer 2 register block
// Assumes: One AXI4-Lite access at a time, ext_clk toggled every cycle
// Notes: Counts are range checks, bus latency blurs the tick phase
`include "tmr2_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module timer2_reload_capture_regs_tb import tmr2_pkg::*; ;
	logic aclk;
	logic aresetn;
	logic [11:0] awaddr;
	logic [11:0] araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic awvalid, wvalid, bready, arvalid, rready, usb_sof, slow_osc;
	logic ext_clk = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [31:0] v;
	logic [1:0] r;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;

	tmr2_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_clk(ext_clk), .usb_sof(usb_sof),
		.slow_osc(slow_osc), .irq(irq));

	// ==========================================
	// Clock, external clock and watchdog
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Two core cycles per external period, so one /8 tick every 16 cycles
	always @(posedge aclk) begin
		ext_clk <= ~ext_clk;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			final_report();
		end
	end

	// ==========================================
	// Bus tasks and checks
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk(bresp, 32'h0000_0000, 32'h0000_0000);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		n_compared++;
		if (((got >= lo) && (got <= hi)) !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic rc(input logic [7:0] idx, input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] d;
		logic [1:0] rs;
		rd(idx, d, rs);
		chk(d, lo, hi);
	endtask

	task automatic pulse_sof;
		@(posedge aclk);
		usb_sof <= 1'b1;
		@(posedge aclk);
		usb_sof <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask

	task automatic final_report;
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================
	// Sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{usb_sof, slow_osc} = 2'h0;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h00000000;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`TMR2_IDX_RLL, 0, 0);
		rc(`TMR2_IDX_CTRL, 0, 0);
		rd(8'h00, v, r);
		chk(r, 2, 2);
		chk(v, 0, 0);
		// 16-bit reload from 0x12AB, core clock on both bytes
		wr(`TMR2_IDX_CKSEL, 8'h03);
		wr(`TMR2_IDX_RLL, 8'hAB);
		wr(`TMR2_IDX_RLH, 8'h12);
		wr(`TMR2_IDX_CNTL, 8'hFE);
		wr(`TMR2_IDX_CNTH, 8'hFF);
		// Flags read while running: stopping by writing zero clears them too
		wr(`TMR2_IDX_CTRL, 8'h24);
		rd(`TMR2_IDX_CTRL, v, r);
		chk(v[7], 1, 1);
		chk(v[6], 1, 1);
		wr(`TMR2_IDX_CTRL, 8'h00);
		rc(`TMR2_IDX_CNTH, 8'h12, 8'h12);
		rc(`TMR2_IDX_CNTL, 8'hAB, 8'hB8);
		rc(`TMR2_IDX_IRQ_ST, 8'h03, 8'h03);
		wr(`TMR2_IDX_IRQ_EN, 8'h05);
		chk(irq, 1, 1);
		wr(`TMR2_IDX_IRQ_CLR, 8'h01);
		chk(irq, 0, 0);
		wr(`TMR2_IDX_IRQ_CLR, 8'h02);
		// Split: run stopped holds the high byte, low byte keeps going
		wr(`TMR2_IDX_CTRL, 8'h08);
		wr(`TMR2_IDX_CNTH, 8'hFE);
		wr(`TMR2_IDX_CNTL, 8'h00);
		rc(`TMR2_IDX_CNTH, 8'hFE, 8'hFE);
		rc(`TMR2_IDX_CNTL, 8'h01, 8'hFF);
		wr(`TMR2_IDX_CTRL, 8'h0C);
		wr(`TMR2_IDX_CTRL, 8'h08);
		rc(`TMR2_IDX_CNTH, 8'h12, 8'h1F);
		rc(`TMR2_IDX_IRQ_ST, 8'h01, 8'h01);
		wr(`TMR2_IDX_IRQ_CLR, 8'h01);
		// Prescaled low byte: div12, then external div8
		wr(`TMR2_IDX_CKSEL, 8'h00);
		wr(`TMR2_IDX_CNTL, 8'h00);
		repeat (120) @(posedge aclk);
		rc(`TMR2_IDX_CNTL, 8'h09, 8'h0C);
		wr(`TMR2_IDX_CTRL, 8'h09);
		wr(`TMR2_IDX_CNTL, 8'h00);
		repeat (160) @(posedge aclk);
		rc(`TMR2_IDX_CNTL, 8'h09, 8'h0C);
		// Capture on start-of-frame, run clear in 16-bit mode holds the counts
		wr(`TMR2_IDX_CTRL, 8'h10);
		wr(`TMR2_IDX_CNTL, 8'h5A);
		wr(`TMR2_IDX_CNTH, 8'hC3);
		pulse_sof();
		rc(`TMR2_IDX_RLL, 8'h5A, 8'h5B);
		rc(`TMR2_IDX_RLH, 8'hC3, 8'hC3);
		rc(`TMR2_IDX_IRQ_ST, 8'h04, 8'h04);
		chk(irq, 1, 1);
		wr(`TMR2_IDX_IRQ_CLR, 8'h04);
		chk(irq, 0, 0);
		// Slow oscillator source: frame pulse and rising edge ignored
		wr(`TMR2_IDX_CTRL, 8'h12);
		wr(`TMR2_IDX_CNTL, 8'h21);
		wr(`TMR2_IDX_CNTH, 8'h43);
		pulse_sof();
		slow_osc <= 1'b1;
		repeat (3) @(posedge aclk);
		rc(`TMR2_IDX_RLL, 8'h5A, 8'h5B);
		slow_osc <= 1'b0;
		repeat (3) @(posedge aclk);
		rc(`TMR2_IDX_RLL, 8'h21, 8'h22);
		rc(`TMR2_IDX_RLH, 8'h43, 8'h43);
		final_report();
	end
endmodule
`default_nettype wire
